// ==== design/ctbo_core.sv ====
// Purpose: Executes jump, stack, no-operation and bit commands of the core.
// Assumes: Commands arrive decoded; core registers are reached over APB.
// Notes:   Internal data memory is a local array; working registers sit at 0..7.
// Summary of operation
// - Long jump: three bytes, one cycle, full target.
// - Page jump: two bytes, replaces low eleven bits.
// - Short jump adds displacement, one cycle.
// - Indirect jump: work register plus data pointer.
// - Zero tests branch after advancing two, two cycles.
// - Carry set jump, two bytes, two cycles.
// - Carry clear jump, two bytes, two cycles.
// - Bit test jumps: three bytes, two cycles.
// - Test-clear jump clears set bit and branches.
// - Compare jumps branch on unequal, carry if less.
// - Register immediate compare completes in one cycle.
// - Decrement jump branches on nonzero result.
// - Pop reads stack, then decrements pointer.
// - No operation only advances program counter.
// - And/or bit into carry, only carry changes.
// - Stack pointer resets to seven, others zero.
// - Idle select register resets to zero.
// - Displacements are sign-extended eight-bit values.
//
// Design decision made here: the APB interface to the registers.
module ctbo_core #(
    parameter int IRAM_DEPTH = 256
) (
    // Clock and reset.
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst,
    // Decoded command stream.
    input  wire ctbo_pkg::ctbo_cmd_t     i_cmd,
    output logic                         o_ready,
    output logic                         o_done,
    // Architectural state.
    output logic [15:0]                  o_pc,
    output logic                         o_carry,
    // APB register port.
    input  wire ctbo_pkg::ctbo_apb_req_t i_apb,
    output ctbo_pkg::ctbo_apb_rsp_t      o_apb
);
    import ctbo_pkg::*;

    // ==========================================================
    // State
    logic [7:0]  stack_pointer;
    logic [7:0]  data_pointer_low;
    logic [7:0]  data_pointer_high;
    logic [7:0]  idle_select_reg;
    logic [7:0]  main_work_reg;
    logic [7:0]  multiply_divide_aux;
    logic        carry_flag;
    logic [15:0] pc;
    logic [7:0]  iram [0:IRAM_DEPTH-1];
    ctbo_state_t state;
    ctbo_state_t next_state;
    ctbo_cmd_t   held;
    ctbo_cmd_t   cur;
    logic        accept;
    logic        two;
    logic        go;
    logic [15:0] pc_adv;
    logic [15:0] br;
    logic [7:0]  bit_addr_byte;
    logic [7:0]  bit_byte;
    logic [7:0]  bit_mask;
    logic        bit_val;
    logic [7:0]  dir_val;
    logic [7:0]  reg_val;
    logic [7:0]  ind_val;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [7:0]  dec_val;
    logic [15:0] next_pc;
    logic        next_carry;
    logic        bit_we;
    logic        new_bit;
    logic        dir_we;
    logic [7:0]  dir_addr;
    logic [7:0]  dir_data;
    logic        ind_we;
    logic [7:0]  ind_addr;
    logic [7:0]  ind_data;
    logic        sp_we;
    logic [7:0]  next_sp;
    logic [7:0]  apb_idx;
    logic [7:0]  apb_rd;
    logic        apb_hit;
    logic        apb_setup;
    logic        apb_we;

    assign o_pc    = pc;
    assign o_carry = carry_flag;

    // ==========================================================
    // Helper functions
    // Byte length of each command kind.
    function automatic logic [15:0] ins_len(input ctbo_kind_t k);
        case (k)
            K_LONG_JUMP, K_JUMP_ON_BIT_SET, K_JUMP_ON_BIT_CLEAR, K_JUMP_TEST_CLEAR_BIT,
            K_CMP_WORK_DIR, K_CMP_WORK_IMM, K_CMP_REG_IMM, K_CMP_IND_IMM,
            K_DEC_JUMP_DIR: return LEN_3;
            K_INDIRECT_JUMP, K_NO_OPERATION, K_CARRY_CLEAR, K_CARRY_SET,
            K_CARRY_INV: return LEN_1;
            default: return LEN_2;
        endcase
    endfunction

    // Kinds that finish in one cycle; everything else needs a second.
    function automatic logic two_cycle(input ctbo_kind_t k);
        case (k)
            K_LONG_JUMP, K_PAGE_JUMP, K_SHORT_JUMP, K_INDIRECT_JUMP, K_CMP_REG_IMM,
            K_DEC_JUMP_REG, K_NO_OPERATION, K_CARRY_CLEAR, K_CARRY_SET,
            K_CARRY_INV: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction

    // Direct space read: low half is memory, upper half the core registers.
    function automatic logic [7:0] rd_dir(input logic [7:0] a);
        if (a < DIRECT_SFR_BASE) begin
            return iram[a];
        end
        case (a)
            OFS_STACK_POINTER: return stack_pointer;
            OFS_DATA_PTR_LOW:  return data_pointer_low;
            OFS_DATA_PTR_HIGH: return data_pointer_high;
            OFS_IDLE_SELECT:   return idle_select_reg;
            OFS_MAIN_WORK:     return main_work_reg;
            OFS_MUL_DIV_AUX:   return multiply_divide_aux;
            default:           return BYTE_ZERO;
        endcase
    endfunction

    // ==========================================================
    // Sequencing
    assign accept = o_ready && i_cmd.valid;
    assign two    = two_cycle(i_cmd.kind);
    assign go     = (state == ST_IDLE && accept && !two) || state == ST_EXEC;
    assign cur    = (state == ST_EXEC) ? held : i_cmd;

    // Two-cycle kinds park in the holding register and execute on the second edge.
    always_comb begin
        case (state)
            ST_IDLE: next_state = (accept && two) ? ST_EXEC : ST_IDLE;
            ST_EXEC: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // State, ready and completion pulse.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state   <= ST_IDLE;
            o_ready <= 1'b0;
            o_done  <= 1'b0;
            held    <= '0;
        end else begin
            state   <= next_state;
            o_ready <= (next_state == ST_IDLE);
            o_done  <= go;
            if (accept) begin
                held <= i_cmd;
            end
        end
    end

    // ==========================================================
    // Operand fetch
    // Bit addresses below the register half map into the byte block at the base.
    always_comb begin
        pc_adv        = pc + ins_len(cur.kind);
        br            = pc_adv + {{REL_EXT_W{cur.rel[REL_EXT_W-1]}}, cur.rel};
        bit_addr_byte = (cur.addr < DIRECT_SFR_BASE) ? BIT_RAM_BASE + (cur.addr >> BIT_SEL_W)
                                                     : (cur.addr >> BIT_SEL_W) << BIT_SEL_W;
        bit_byte      = rd_dir(bit_addr_byte);
        bit_mask      = INC_ONE << cur.addr[BIT_SEL_W-1:0];
        bit_val       = |(bit_byte & bit_mask);
        dir_val       = rd_dir(cur.addr);
        reg_val       = iram[8'(cur.reg_sel)];
        ind_val       = iram[iram[8'(cur.reg_sel[0])]];
        cmp_a         = (cur.kind == K_CMP_WORK_DIR || cur.kind == K_CMP_WORK_IMM) ? main_work_reg
                      : (cur.kind == K_CMP_REG_IMM) ? reg_val : ind_val;
        cmp_b         = (cur.kind == K_CMP_WORK_DIR) ? dir_val : cur.imm;
        dec_val       = ((cur.kind == K_DEC_JUMP_REG) ? reg_val : dir_val) - INC_ONE;
    end

    // ==========================================================
    // Execution
    // All effects are computed from the pre-edge state, so a read and its
    // write back land on the same edge and nothing can slip in between.
    always_comb begin
        next_pc    = pc_adv;
        next_carry = carry_flag;
        bit_we     = 1'b0;
        new_bit    = 1'b0;
        sp_we      = 1'b0;
        next_sp    = stack_pointer;
        ind_we     = 1'b0;
        ind_addr   = stack_pointer;
        ind_data   = dir_val;
        dir_we     = 1'b0;
        dir_addr   = cur.addr;
        dir_data   = BYTE_ZERO;
        case (cur.kind)
            K_LONG_JUMP:         next_pc = cur.target;
            K_PAGE_JUMP:         next_pc = {pc_adv[15:PAGE_W], cur.target[PAGE_W-1:0]};
            K_SHORT_JUMP:        next_pc = br;
            K_INDIRECT_JUMP:     next_pc = {data_pointer_high, data_pointer_low} + 16'(main_work_reg);
            K_JUMP_IF_ZERO:      if (main_work_reg == BYTE_ZERO) next_pc = br;
            K_JUMP_IF_NONZERO:   if (main_work_reg != BYTE_ZERO) next_pc = br;
            K_JUMP_ON_CARRY:     if (carry_flag) next_pc = br;
            K_JUMP_ON_NO_CARRY:  if (!carry_flag) next_pc = br;
            K_JUMP_ON_BIT_SET:   if (bit_val) next_pc = br;
            K_JUMP_ON_BIT_CLEAR: if (!bit_val) next_pc = br;
            K_JUMP_TEST_CLEAR_BIT: begin
                if (bit_val) begin
                    next_pc = br;
                    bit_we  = 1'b1;
                end
            end
            K_CMP_WORK_DIR, K_CMP_WORK_IMM, K_CMP_REG_IMM, K_CMP_IND_IMM: begin
                if (cmp_a != cmp_b) next_pc = br;
                next_carry = (cmp_a < cmp_b);
            end
            K_DEC_JUMP_REG, K_DEC_JUMP_DIR: begin
                dir_we   = 1'b1;
                dir_addr = (cur.kind == K_DEC_JUMP_REG) ? 8'(cur.reg_sel) : cur.addr;
                dir_data = dec_val;
                if (dec_val != BYTE_ZERO) next_pc = br;
            end
            K_PUSH: begin
                sp_we    = 1'b1;
                next_sp  = stack_pointer + INC_ONE;
                ind_we   = 1'b1;
                ind_addr = next_sp;
            end
            K_POP: begin
                dir_we   = 1'b1;
                dir_data = iram[stack_pointer];
                sp_we    = 1'b1;
                next_sp  = stack_pointer - INC_ONE;
            end
            K_NO_OPERATION:   next_pc = pc_adv;
            K_CARRY_FROM_BIT: next_carry = bit_val;
            K_BIT_FROM_CARRY: begin
                bit_we  = 1'b1;
                new_bit = carry_flag;
            end
            K_CARRY_CLEAR: next_carry = 1'b0;
            K_CARRY_SET:   next_carry = 1'b1;
            K_CARRY_INV:   next_carry = !carry_flag;
            K_BIT_CLEAR:   bit_we = 1'b1;
            K_BIT_SET: begin
                bit_we  = 1'b1;
                new_bit = 1'b1;
            end
            K_BIT_INV: begin
                bit_we  = 1'b1;
                new_bit = !bit_val;
            end
            K_AND_BIT:  next_carry = carry_flag & bit_val;
            K_AND_NBIT: next_carry = carry_flag & !bit_val;
            K_OR_BIT:   next_carry = carry_flag | bit_val;
            K_OR_NBIT:  next_carry = carry_flag | !bit_val;
            default: ;
        endcase
        if (bit_we) begin
            dir_we   = 1'b1;
            dir_addr = bit_addr_byte;
            dir_data = new_bit ? (bit_byte | bit_mask) : (bit_byte & ~bit_mask);
        end
    end

    // ==========================================================
    // Register updates
    // Execution is written last so it wins over a same-edge bus write.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stack_pointer       <= RST_STACK_POINTER;
            data_pointer_low    <= BYTE_ZERO;
            data_pointer_high   <= BYTE_ZERO;
            idle_select_reg     <= BYTE_ZERO;
            main_work_reg       <= BYTE_ZERO;
            multiply_divide_aux <= BYTE_ZERO;
        end else begin
            if (apb_we) begin
                case (apb_idx)
                    OFS_STACK_POINTER: stack_pointer       <= i_apb.pwdata[7:0];
                    OFS_DATA_PTR_LOW:  data_pointer_low    <= i_apb.pwdata[7:0];
                    OFS_DATA_PTR_HIGH: data_pointer_high   <= i_apb.pwdata[7:0];
                    OFS_IDLE_SELECT:   idle_select_reg     <= i_apb.pwdata[7:0];
                    OFS_MAIN_WORK:     main_work_reg       <= i_apb.pwdata[7:0];
                    OFS_MUL_DIV_AUX:   multiply_divide_aux <= i_apb.pwdata[7:0];
                    default: ;
                endcase
            end
            if (go && sp_we) begin
                stack_pointer <= next_sp;
            end
            // A pop into the pointer itself keeps the popped byte.
            if (go && dir_we) begin
                case (dir_addr)
                    OFS_STACK_POINTER: stack_pointer       <= dir_data;
                    OFS_DATA_PTR_LOW:  data_pointer_low    <= dir_data;
                    OFS_DATA_PTR_HIGH: data_pointer_high   <= dir_data;
                    OFS_IDLE_SELECT:   idle_select_reg     <= dir_data;
                    OFS_MAIN_WORK:     main_work_reg       <= dir_data;
                    OFS_MUL_DIV_AUX:   multiply_divide_aux <= dir_data;
                    default: ;
                endcase
            end
        end
    end

    // Program counter and carry.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pc         <= RST_PC;
            carry_flag <= 1'b0;
        end else begin
            if (apb_we && apb_idx == OFS_PC_LOW) pc[7:0] <= i_apb.pwdata[7:0];
            if (apb_we && apb_idx == OFS_PC_HIGH) pc[15:8] <= i_apb.pwdata[7:0];
            if (apb_we && apb_idx == OFS_FLAGS) carry_flag <= i_apb.pwdata[0];
            if (go) begin
                pc         <= next_pc;
                carry_flag <= next_carry;
            end
        end
    end

    // Internal memory has no reset; contents are undefined until written.
    always_ff @(posedge i_clk_sys) begin
        if (go && ind_we) iram[ind_addr] <= ind_data;
        if (go && dir_we && dir_addr < DIRECT_SFR_BASE) iram[dir_addr] <= dir_data;
    end

    // ==========================================================
    // APB slave
    // Zero wait states: the answer is ready in the first access cycle.
    assign apb_idx   = i_apb.paddr[APB_AW-1:APB_IDX_LSB];
    assign apb_setup = i_apb.psel && !i_apb.penable;
    assign apb_we    = i_apb.psel && i_apb.penable && i_apb.pwrite && o_apb.pready && !o_apb.pslverr;

    always_comb begin
        apb_hit = (i_apb.paddr[APB_IDX_LSB-1:0] == '0);
        case (apb_idx)
            OFS_PC_LOW:  apb_rd = pc[7:0];
            OFS_PC_HIGH: apb_rd = pc[15:8];
            OFS_FLAGS:   apb_rd = 8'(carry_flag);
            OFS_STACK_POINTER, OFS_DATA_PTR_LOW, OFS_DATA_PTR_HIGH, OFS_IDLE_SELECT,
            OFS_MAIN_WORK, OFS_MUL_DIV_AUX: apb_rd = rd_dir(apb_idx);
            default: begin
                apb_rd  = BYTE_ZERO;
                apb_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_apb <= '0;
        end else begin
            o_apb.pready <= apb_setup;
            if (apb_setup) begin
                o_apb.prdata  <= i_apb.pwrite ? '0 : 32'(apb_rd);
                o_apb.pslverr <= !apb_hit;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    chk_long_target: assert property (go && cur.kind == K_LONG_JUMP |=> pc == $past(cur.target))
        else $error("long jump target wrong");
    chk_page_bits: assert property (go && cur.kind == K_PAGE_JUMP |=>
        pc[PAGE_W-1:0] == $past(cur.target[PAGE_W-1:0]) && pc[15:PAGE_W] == $past(pc_adv[15:PAGE_W]))
        else $error("page jump bits wrong");
    chk_short_rel: assert property (go && cur.kind == K_SHORT_JUMP |=>
        pc == 16'($past(pc) + LEN_2 + {{REL_EXT_W{$past(cur.rel[7])}}, $past(cur.rel)}))
        else $error("short jump displacement wrong");
    chk_one_cycle: assert property (accept && !two |=> o_done && o_ready)
        else $error("one cycle command not done");
    chk_two_cycle: assert property (accept && two |=> !o_ready && !o_done ##1 o_done && o_ready)
        else $error("two cycle timing wrong");
    chk_zero_skip: assert property (go && cur.kind == K_JUMP_IF_ZERO && main_work_reg != BYTE_ZERO
        |=> pc == 16'($past(pc) + LEN_2))
        else $error("zero test fell through wrongly");
    chk_cmp_carry: assert property (go && cur.kind inside {K_CMP_WORK_DIR, K_CMP_WORK_IMM, K_CMP_REG_IMM,
        K_CMP_IND_IMM} |=> carry_flag == $past(cmp_a < cmp_b))
        else $error("compare carry wrong");
    chk_push_ptr: assert property (go && cur.kind == K_PUSH |=> stack_pointer == 8'($past(stack_pointer) + 1))
        else $error("push pointer wrong");
    chk_pop_ptr: assert property (go && cur.kind == K_POP && cur.addr != OFS_STACK_POINTER
        |=> stack_pointer == 8'($past(stack_pointer) - 1))
        else $error("pop pointer wrong");
    chk_idle_state: assert property (go && cur.kind == K_NO_OPERATION |=>
        pc == 16'($past(pc) + LEN_1) && $stable(carry_flag) && $stable(main_work_reg))
        else $error("no operation changed state");
    chk_bit_carry: assert property (go && cur.kind == K_BIT_FROM_CARRY |=> $stable(carry_flag))
        else $error("carry store changed carry");

    cov_zero_taken: cover property (go && cur.kind == K_JUMP_IF_ZERO && main_work_reg == BYTE_ZERO);
    cov_test_clear: cover property (go && cur.kind == K_JUMP_TEST_CLEAR_BIT && bit_val);
    cov_push_pop:   cover property (go && cur.kind == K_PUSH ##[1:8] go && cur.kind == K_POP);
    cov_apb_write:  cover property (apb_we && apb_idx == OFS_STACK_POINTER);
endmodule

// ==== inc/ctbo_pkg.sv ====
// Purpose: Shared constants and types for the control transfer and bit unit.
// Assumes: Register indices are byte addresses divided by four on APB.
// Notes:   Command kinds are an internal encoding, not opcode bytes.
package ctbo_pkg;
    // ==========================================================
    // Bus and register map
    localparam int         APB_AW            = 10;
    localparam int         APB_IDX_LSB       = 2;
    localparam logic [7:0] OFS_PC_LOW        = 8'h01;
    localparam logic [7:0] OFS_PC_HIGH       = 8'h02;
    localparam logic [7:0] OFS_FLAGS         = 8'h03;
    localparam logic [7:0] OFS_STACK_POINTER = 8'h81;
    localparam logic [7:0] OFS_DATA_PTR_LOW  = 8'h82;
    localparam logic [7:0] OFS_DATA_PTR_HIGH = 8'h83;
    localparam logic [7:0] OFS_IDLE_SELECT   = 8'h87;
    localparam logic [7:0] OFS_MAIN_WORK     = 8'he0;
    localparam logic [7:0] OFS_MUL_DIV_AUX   = 8'hf0;
    // ==========================================================
    // Reset values and small constants
    localparam logic [7:0]  RST_STACK_POINTER = 8'h07;
    localparam logic [7:0]  BYTE_ZERO         = 8'h00;
    localparam logic [7:0]  INC_ONE           = 8'h01;
    localparam logic [15:0] RST_PC            = 16'h0000;
    localparam logic [15:0] LEN_1             = 16'h0001;
    localparam logic [15:0] LEN_2             = 16'h0002;
    localparam logic [15:0] LEN_3             = 16'h0003;
    localparam logic [7:0]  DIRECT_SFR_BASE   = 8'h80;
    localparam logic [7:0]  BIT_RAM_BASE      = 8'h20;
    localparam int          BIT_SEL_W         = 3;
    localparam int          PAGE_W            = 11;
    localparam int          REL_EXT_W         = 8;
    // ==========================================================
    // Commands and states
    typedef enum logic [4:0] {
        K_LONG_JUMP, K_PAGE_JUMP, K_SHORT_JUMP, K_INDIRECT_JUMP,
        K_JUMP_IF_ZERO, K_JUMP_IF_NONZERO, K_JUMP_ON_CARRY, K_JUMP_ON_NO_CARRY,
        K_JUMP_ON_BIT_SET, K_JUMP_ON_BIT_CLEAR, K_JUMP_TEST_CLEAR_BIT,
        K_CMP_WORK_DIR, K_CMP_WORK_IMM, K_CMP_REG_IMM, K_CMP_IND_IMM,
        K_DEC_JUMP_REG, K_DEC_JUMP_DIR, K_PUSH, K_POP, K_NO_OPERATION,
        K_CARRY_FROM_BIT, K_BIT_FROM_CARRY, K_CARRY_CLEAR, K_BIT_CLEAR,
        K_CARRY_SET, K_BIT_SET, K_CARRY_INV, K_BIT_INV,
        K_AND_BIT, K_AND_NBIT, K_OR_BIT, K_OR_NBIT
    } ctbo_kind_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} ctbo_state_t;
    typedef struct packed {
        logic        valid;
        ctbo_kind_t  kind;
        logic [2:0]  reg_sel;
        logic [7:0]  addr;
        logic [7:0]  imm;
        logic [7:0]  rel;
        logic [15:0] target;
    } ctbo_cmd_t;
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } ctbo_apb_req_t;
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } ctbo_apb_rsp_t;
endpackage

// ==== tb/ctbo_prog_src.sv ====
// Purpose: Program source model that hands decoded commands to the core.
// Assumes: The bench loads one command at a time.
// Notes:   Fields are scrambled after a take so stale values are never reused.
module ctbo_prog_src (
    // Clock, reset and load side.
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire logic                i_load,
    input  wire ctbo_pkg::ctbo_cmd_t i_next,
    // Core side.
    input  wire logic                i_ready,
    output ctbo_pkg::ctbo_cmd_t      o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    import ctbo_pkg::*;
    // ==========================================================
    // Valid holds until the core takes the command.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_cmd <= '0;
        end else if (i_load) begin
            o_cmd <= i_next;
        end else if (o_cmd.valid && i_ready) begin
            o_cmd <= {1'b0, ~o_cmd[$bits(ctbo_cmd_t)-2:0]};
        end
    end
endmodule

// ==== tb/ctbo_tb_top.sv ====
// Purpose: Self-checking bench for the control transfer and bit unit.
// Assumes: Zero-wait APB slave; commands come from the program source model.
// Notes:   The expected program counter is tracked by the bench alone.
module ctbo_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ctbo_pkg::*;
    logic          clk, rst, load, rdy, done, cy, er;
    ctbo_cmd_t     nc, cmd;
    ctbo_apb_req_t req;
    ctbo_apb_rsp_t rsp;
    logic [15:0]   pc, epc, t;
    logic [31:0]   seed = 32'h42, rd;
    logic [7:0]    w, r;
    logic [7:0]    ofs [6] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'he0, 8'hf0};
    int            bad_count, num_checks, n;
    // ==========================================================
    // Clock, design and program source.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ctbo_core DUT (.i_clk_sys(clk), .i_rst(rst), .i_cmd(cmd), .o_ready(rdy), .o_done(done),
                   .o_pc(pc), .o_carry(cy), .i_apb(req), .o_apb(rsp));
    ctbo_prog_src SRC (.i_clk_sys(clk), .i_rst(rst), .i_load(load), .i_next(nc), .i_ready(rdy), .o_cmd(cmd));
    // ==========================================================
    // Helpers.
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] sx(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {24'h0, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    // Issue a command, count cycles to done, compare the program counter.
    task automatic run(input ctbo_kind_t k, input logic [7:0] a, imm, rel, input logic [15:0] tg, input int cyc);
        @(posedge clk);
        nc <= '{1'b1, k, 3'd0, a, imm, rel, tg};
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 8);
        chk(n, cyc + 1);
        chk(rdy, 1'b1);
        chk(pc, epc);
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog, far beyond the 150 or so cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
    // ==========================================================
    // Main sequence.
    initial begin
        rst = 1'b1;
        load = 1'b0;
        nc = '0;
        req = '0;
        epc = 16'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 8'h00);
            chk(rd, (i == 0) ? 32'h7 : 32'h0);
        end
        apb(1'b0, 8'h90, 8'h00);
        chk(er, 1'b1);
        $display("Test registers done");
        for (int i = 0; i < 3; i++) begin
            t = 16'(xs());
            r = (i == 0) ? 8'h80 : 8'(xs());
            epc = t;
            run(K_LONG_JUMP, 8'h00, 8'h00, 8'h00, t, 1);
            t = 16'(xs());
            epc = epc + 16'h2;
            epc = {epc[15:11], t[10:0]};
            run(K_PAGE_JUMP, 8'h00, 8'h00, 8'h00, t, 1);
            epc = epc + 16'h2 + sx(r);
            run(K_SHORT_JUMP, 8'h00, 8'h00, r, 16'h0, 1);
        end
        t = 16'(xs());
        w = (8'(xs()) & 8'h7f) | 8'h01;
        apb(1'b1, 8'h82, t[7:0]);
        apb(1'b1, 8'h83, t[15:8]);
        apb(1'b1, 8'he0, w);
        epc = t + {8'h0, w};
        run(K_INDIRECT_JUMP, 8'h00, 8'h00, 8'h00, 16'h0, 1);
        epc = epc + 16'h2;
        run(K_JUMP_IF_ZERO, 8'h00, 8'h00, 8'h10, 16'h0, 2);
        epc = epc + 16'h12;
        run(K_JUMP_IF_NONZERO, 8'h00, 8'h00, 8'h10, 16'h0, 2);
        for (int c = 0; c < 2; c++) begin
            epc = epc + 16'h1;
            run(c ? K_CARRY_SET : K_CARRY_CLEAR, 8'h00, 8'h00, 8'h00, 16'h0, 1);
            chk(cy, c[0]);
            epc = epc + 16'h2 + (c ? 16'h4 : 16'h0);
            run(K_JUMP_ON_CARRY, 8'h00, 8'h00, 8'h04, 16'h0, 2);
            epc = epc + 16'h2 + (c ? 16'h0 : 16'h4);
            run(K_JUMP_ON_NO_CARRY, 8'h00, 8'h00, 8'h04, 16'h0, 2);
        end
        epc = epc + 16'h1;
        run(K_NO_OPERATION, 8'h00, 8'h00, 8'h00, 16'h0, 1);
        $display("Test jumps done");
        epc = epc + 16'h2;
        run(K_PUSH, 8'he0, 8'h00, 8'h00, 16'h0, 2);
        apb(1'b0, 8'h81, 8'h00);
        chk(rd, 32'h8);
        epc = epc + 16'h2;
        run(K_POP, 8'h00, 8'h00, 8'h00, 16'h0, 2);
        apb(1'b0, 8'h81, 8'h00);
        chk(rd, 32'h7);
        r = 8'(xs());
        epc = epc + 16'h3 + sx(r);
        run(K_CMP_REG_IMM, 8'h00, 8'hff, r, 16'h0, 1);
        chk(cy, 1'b1);
        epc = epc + 16'h3;
        run(K_CMP_REG_IMM, 8'h00, w, r, 16'h0, 1);
        chk(cy, 1'b0);
        epc = epc + 16'h2 + ((w != 8'h01) ? sx(r) : 16'h0);
        run(K_DEC_JUMP_REG, 8'h00, 8'h00, r, 16'h0, 1);
        $display("Test stack and compare done");
        // Bit 0 of the work register is known to be 1 here, since w is odd.
        epc = epc + 16'h7;
        run(K_JUMP_ON_BIT_SET, 8'he0, 8'h00, 8'h04, 16'h0, 2);
        epc = epc + 16'h7;
        run(K_JUMP_TEST_CLEAR_BIT, 8'he0, 8'h00, 8'h04, 16'h0, 2);
        epc = epc + 16'h7;
        run(K_JUMP_ON_BIT_CLEAR, 8'he0, 8'h00, 8'h04, 16'h0, 2);
        epc = epc + 16'h2;
        run(K_BIT_SET, 8'he0, 8'h00, 8'h00, 16'h0, 2);
        epc = epc + 16'h2;
        run(K_CARRY_FROM_BIT, 8'he0, 8'h00, 8'h00, 16'h0, 2);
        chk(cy, 1'b1);
        epc = epc + 16'h2;
        run(K_AND_NBIT, 8'he0, 8'h00, 8'h00, 16'h0, 2);
        chk(cy, 1'b0);
        apb(1'b0, 8'he0, 8'h00);
        chk(rd, {24'h0, w});
        $display("Test bits done");
        stop_test();
    end
endmodule
